// ---- logic/ptm_pkg.sv ----
// Shared constants and types for the test mode entry control block
package ptm_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS    = 50;                                               // 20 MHz clock
	localparam int PD_SETTLE_NS     = 1000;                                             // Power-down settle time
	localparam int PD_SETTLE_CYCLES = (PD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Least time, rounded up
	localparam int IND_SENSE_NS     = 2000;                                             // Indicator sense window
	localparam int IND_SENSE_CYCLES = (IND_SENSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Least time, rounded up

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00; // Control
	localparam logic [7:0] ADDR_STATUS = 8'h04; // Status, read only
	localparam logic [7:0] ADDR_IND    = 8'h08; // Indicator polarity modes
	localparam logic [7:0] ADDR_RESET  = 8'h0C; // Software reset, write only

	// Control register fields
	localparam int CTRL_PD_BIT   = 0; // Soft power-down request
	localparam int CTRL_AN_BIT   = 1; // Autonegotiation allow
	localparam int CTRL_FRC_BIT  = 2; // Autonegotiation forced configuration
	localparam int CTRL_ZERO_BIT = 3; // Zero symbol transmit mode
	localparam int CTRL_PAT_LSB  = 4; // Test pattern select, two bits
	localparam int CTRL_LVL_BIT  = 6; // High transmit level request

	// Status register fields
	localparam int ST_PD_BIT     = 0; // Soft power-down reached
	localparam int ST_STRAP_BIT  = 1; // Strap sampled high
	localparam int ST_LVL_BIT    = 2; // High transmit level in use
	localparam int ST_IND_A_BIT  = 3; // Indicator A sensed active high
	localparam int ST_IND_B_BIT  = 4; // Indicator B sensed active high
	localparam int ST_SENSE_BIT  = 5; // Polarity sensing in progress
	localparam int ST_TX_BIT     = 6; // Transmit path enabled

	// Indicator register fields and reset register field
	localparam int IND_A_LSB     = 0; // Indicator A mode, two bits
	localparam int IND_B_LSB     = 2; // Indicator B mode, two bits
	localparam int RESET_BIT     = 0; // Software reset trigger

	// Reset values of control bits
	localparam logic PD_REQ_RESET   = 1'b0;
	localparam logic AN_ALLOW_RESET = 1'b1;
	localparam logic FORCED_RESET   = 1'b0;
	localparam logic ZERO_RESET     = 1'b0;
	localparam logic LVL_REQ_RESET  = 1'b0;

	// Transmit symbol codes
	localparam logic [1:0] SYM_ZERO  = 2'h0;
	localparam logic [1:0] SYM_PLUS  = 2'h1;
	localparam logic [1:0] SYM_MINUS = 2'h3;

	// Droop pattern half length in symbols
	localparam logic [4:0] DROOP_HALF = 5'h0A;

	// Test pattern codes, all-zero is normal operation
	typedef enum logic [1:0] {PTM_PAT_NORMAL, PTM_PAT_ALT, PTM_PAT_DROOP, PTM_PAT_IDLE} ptm_pattern_type;

	// Indicator polarity modes, autosense first so reset selects it
	typedef enum logic [1:0] {PTM_IND_AUTO, PTM_IND_LOW, PTM_IND_HIGH, PTM_IND_SPARE} ptm_ind_mode_type;

endpackage : ptm_pkg

// ---- logic/ptm_indicator.sv ----
// Indicator output driver with polarity sensing
`timescale 1ns/10ps
module ptm_indicator #(
	parameter int SENSE_CYCLES = ptm_pkg::IND_SENSE_CYCLES
) (
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire ptm_pkg::ptm_ind_mode_type  mode,
	input  wire logic                       sense_start,
	input  wire logic                       activity,
	input  wire logic                       pin_in,
	output logic                            pin_out,
	output logic                            pin_oe,
	output logic                            active_high,
	output logic                            sense_busy
);

	// Sense window must cover the pin synchroniser
	if (SENSE_CYCLES < 3 || SENSE_CYCLES > 1000)
	begin : g_chk
		$error("ptm_indicator: SENSE_CYCLES out of range");
	end

	localparam int SENSE_LIMIT = SENSE_CYCLES;

	// Sensing first, then normal drive
	typedef enum logic {PTM_IND_SENSE, PTM_IND_RUN} ptm_ind_phase_type;

	typedef struct packed {
		logic              sync1;         // Pin synchroniser, first stage
		logic              sync2;         // Pin synchroniser, second stage
		ptm_ind_phase_type phase;         // Sensing or driving
		logic [15:0]       count;         // Sense window counter
		logic              polarity_high; // Sensed polarity
		logic              out;           // Pin output level
		logic              oe;            // Pin output enable
	} ptm_ind_state_type;

	ptm_ind_state_type st;      // Registered state
	ptm_ind_state_type next_st; // Next state
	logic              eff_high; // Polarity in use

	// Next state logic
	always_comb
	begin
		next_st       = st;
		eff_high      = 1'b0;
		next_st.sync1 = pin_in;
		next_st.sync2 = st.sync1;
		case (mode)
			ptm_pkg::PTM_IND_HIGH: eff_high = 1'b1;
			ptm_pkg::PTM_IND_LOW:  eff_high = 1'b0;
			default:               eff_high = st.polarity_high;
		endcase
		case (st.phase)
			PTM_IND_SENSE:
			begin
				// Pin floats so the external pull decides the level
				next_st.oe  = 1'b0;
				next_st.out = 1'b0;
				if (st.count == 16'(SENSE_CYCLES - 1))
				begin
					// Pulled high means the diode hangs from supply, active low
					next_st.polarity_high = ~st.sync2;
					next_st.phase         = PTM_IND_RUN;
					next_st.count         = 16'h0000;
				end
				else
				begin
					next_st.count = st.count + 16'h0001;
				end
			end
			PTM_IND_RUN:
			begin
				// Drive activity in the chosen polarity
				next_st.oe  = 1'b1;
				next_st.out = eff_high ? activity : ~activity;
			end
			default:
			begin
				next_st.phase = PTM_IND_SENSE;
			end
		endcase
		// Software reset restarts sensing
		if (sense_start)
		begin
			next_st.phase = PTM_IND_SENSE;
			next_st.count = 16'h0000;
			next_st.oe    = 1'b0;
			next_st.out   = 1'b0;
		end
	end

	// State register, power-up and hardware reset start in sensing
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	// Outputs
	assign pin_out     = st.out;
	assign pin_oe      = st.oe;
	assign active_high = st.polarity_high;
	assign sense_busy  = (st.phase == PTM_IND_SENSE);

	property p_sense_restart;
		@(posedge clk) disable iff (!nrst)
		sense_start |=> (sense_busy && !pin_oe);
	endproperty
	a_sense_restart: assert property (p_sense_restart) else $error("sense not restarted");

	property p_sense_bound;
		@(posedge clk) disable iff (!nrst)
		(sense_busy && st.count == 16'h0000) |-> ##[1:SENSE_LIMIT] (!sense_busy || sense_start);
	endproperty
	a_sense_bound: assert property (p_sense_bound) else $error("sense window too long");

	property p_mode_high;
		@(posedge clk) disable iff (!nrst)
		(!sense_busy && !sense_start && mode == ptm_pkg::PTM_IND_HIGH) |=> (pin_oe && pin_out == $past(activity));
	endproperty
	a_mode_high: assert property (p_mode_high) else $error("active high drive wrong");

	property p_mode_auto;
		@(posedge clk) disable iff (!nrst)
		(!sense_busy && !sense_start && mode == ptm_pkg::PTM_IND_AUTO)
			|=> (pin_out == ($past(active_high) ? $past(activity) : !$past(activity)));
	endproperty
	a_mode_auto: assert property (p_mode_auto) else $error("autosense drive wrong");

endmodule : ptm_indicator

// ---- logic/ptm_test_entry.sv ----
// Transmitter test mode entry control with register slave, strap and indicators
`timescale 1ns/10ps
module ptm_test_entry #(
	parameter int PD_SETTLE  = ptm_pkg::PD_SETTLE_CYCLES,
	parameter int SENSE_WAIT = ptm_pkg::IND_SENSE_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        high_level_tx_strap,
	input  wire logic [1:0]  pcs_tx_symbol,
	input  wire logic        an_level_high,
	input  wire logic        link_activity_a,
	input  wire logic        link_activity_b,
	input  wire logic        indicator_out_a_in,
	output logic             indicator_out_a_out,
	output logic             indicator_out_a_oe,
	input  wire logic        indicator_out_b_in,
	output logic             indicator_out_b_out,
	output logic             indicator_out_b_oe,
	output logic [1:0]       tx_symbol,
	output logic             tx_path_enable,
	output logic             rx_path_enable,
	output logic             tx_level_high,
	output logic             autoneg_allow,
	output logic             autoneg_forced_config
);

	// Settle counter is eight bits wide, reached flag needs two cycles at least
	if (PD_SETTLE < 2 || PD_SETTLE > 255)
	begin : g_chk
		$error("ptm_test_entry: PD_SETTLE out of range");
	end

	localparam int PD_WAIT = PD_SETTLE + 1; // Bound for the reached flag

	typedef struct packed {
		logic                      pd_req;        // Soft power-down request
		logic                      an_allow;      // Autonegotiation allow
		logic                      an_forced;     // Forced configuration
		logic                      zero_en;       // Zero symbol mode
		ptm_pkg::ptm_pattern_type  pattern;       // Test pattern select
		logic                      lvl_req;       // High level request
		ptm_pkg::ptm_ind_mode_type ind_a_mode;    // Indicator A mode
		ptm_pkg::ptm_ind_mode_type ind_b_mode;    // Indicator B mode
		logic [7:0]                pd_count;      // Power-down settle count
		logic                      pd_reached;    // Power-down reached
		logic                      strap_s1;      // Strap synchroniser, first stage
		logic                      strap_s2;      // Strap synchroniser, second stage
		logic [1:0]                strap_stage;   // Cycles since reset release
		logic                      strap_latched; // Strap level caught
		logic                      strap_done;    // Strap capture complete
		logic [4:0]                pat_count;     // Droop pattern position
		logic                      alt_phase;     // Alternating pattern phase
		logic [1:0]                tx_symbol;     // Symbol to transmitter
		logic                      tx_en;         // Transmit path enable
		logic                      rx_en;         // Receive path enable
		logic                      lvl_high;      // High level in use
		logic [31:0]               rdata;         // Captured read data
		logic                      sense_kick;    // Restart polarity sensing
	} ptm_core_state_type;

	ptm_core_state_type st;       // Registered state
	ptm_core_state_type next_st;  // Next state
	logic               bus_write; // Write takes effect now
	logic               mapped;    // Address hits a register
	logic               run_tx;    // Pattern generator running
	logic               run_alt;   // Alternating pattern running
	logic               run_droop; // Droop pattern running
	logic               ind_a_high; // Indicator A polarity sensed
	logic               ind_b_high; // Indicator B polarity sensed
	logic               ind_a_busy; // Indicator A sensing
	logic               ind_b_busy; // Indicator B sensing

	// Bus decode, zero wait states
	assign mapped    = (paddr == ptm_pkg::ADDR_CTRL) || (paddr == ptm_pkg::ADDR_STATUS) ||
	                   (paddr == ptm_pkg::ADDR_IND) || (paddr == ptm_pkg::ADDR_RESET);
	assign bus_write = psel && penable && pwrite && mapped;
	assign pready    = psel && penable;
	assign pslverr   = psel && penable && !mapped;

	// Which generator is live this cycle
	assign run_tx    = st.tx_en && !st.zero_en;
	assign run_alt   = run_tx && (st.pattern == ptm_pkg::PTM_PAT_ALT);
	assign run_droop = run_tx && (st.pattern == ptm_pkg::PTM_PAT_DROOP);

	// Next state logic
	always_comb
	begin
		next_st            = st;
		next_st.sense_kick = 1'b0;

		// Strap passes two stages, then is caught once
		next_st.strap_s1 = high_level_tx_strap;
		next_st.strap_s2 = st.strap_s1;
		if (st.strap_stage != 2'h2)
			next_st.strap_stage = st.strap_stage + 2'h1;
		else if (!st.strap_done)
		begin
			next_st.strap_latched = st.strap_s2;
			next_st.strap_done    = 1'b1;
		end

		// Register writes
		if (bus_write)
		begin
			case (paddr)
				ptm_pkg::ADDR_CTRL:
				begin
					next_st.pd_req    = pwdata[ptm_pkg::CTRL_PD_BIT];
					next_st.an_allow  = pwdata[ptm_pkg::CTRL_AN_BIT];
					next_st.an_forced = pwdata[ptm_pkg::CTRL_FRC_BIT];
					next_st.pattern   = ptm_pkg::ptm_pattern_type'(pwdata[ptm_pkg::CTRL_PAT_LSB +: 2]);
					next_st.lvl_req   = pwdata[ptm_pkg::CTRL_LVL_BIT];
					// Clearing power-down also leaves zero mode
					if (!pwdata[ptm_pkg::CTRL_PD_BIT])
						next_st.zero_en = 1'b0;
					else
						next_st.zero_en = pwdata[ptm_pkg::CTRL_ZERO_BIT];
				end
				ptm_pkg::ADDR_IND:
				begin
					next_st.ind_a_mode = ptm_pkg::ptm_ind_mode_type'(pwdata[ptm_pkg::IND_A_LSB +: 2]);
					next_st.ind_b_mode = ptm_pkg::ptm_ind_mode_type'(pwdata[ptm_pkg::IND_B_LSB +: 2]);
				end
				ptm_pkg::ADDR_RESET:
				begin
					// Software reset restores control and resamples
					if (pwdata[ptm_pkg::RESET_BIT])
					begin
						next_st.pd_req      = ptm_pkg::PD_REQ_RESET;
						next_st.an_allow    = ptm_pkg::AN_ALLOW_RESET;
						next_st.an_forced   = ptm_pkg::FORCED_RESET;
						next_st.zero_en     = ptm_pkg::ZERO_RESET;
						next_st.lvl_req     = ptm_pkg::LVL_REQ_RESET;
						next_st.pattern     = ptm_pkg::PTM_PAT_NORMAL;
						next_st.ind_a_mode  = ptm_pkg::PTM_IND_AUTO;
						next_st.ind_b_mode  = ptm_pkg::PTM_IND_AUTO;
						next_st.strap_stage = 2'h0;
						next_st.strap_done  = 1'b0;
						next_st.sense_kick  = 1'b1;
					end
				end
				default:
				begin
					next_st.sense_kick = 1'b0;
				end
			endcase
		end

		// Power-down reached after the settle time
		if (!st.pd_req)
		begin
			next_st.pd_count   = 8'h00;
			next_st.pd_reached = 1'b0;
		end
		else if (!st.pd_reached)
		begin
			if (st.pd_count == 8'(PD_SETTLE - 1))
				next_st.pd_reached = 1'b1;
			else
				next_st.pd_count = st.pd_count + 8'h01;
		end

		// Paths live out of power-down, or in zero mode
		next_st.tx_en = !st.pd_req || st.zero_en;
		next_st.rx_en = !st.pd_req || st.zero_en;

		// Pattern sequencers idle unless their pattern runs
		next_st.alt_phase = run_alt ? !st.alt_phase : 1'b0;
		if (run_droop && st.pat_count != 5'h13)
			next_st.pat_count = st.pat_count + 5'h01;
		else
			next_st.pat_count = 5'h00;

		// Transmit symbol choice
		if (!st.tx_en || st.zero_en)
			next_st.tx_symbol = ptm_pkg::SYM_ZERO;
		else
		begin
			case (st.pattern)
				ptm_pkg::PTM_PAT_ALT:
					next_st.tx_symbol = st.alt_phase ? ptm_pkg::SYM_MINUS : ptm_pkg::SYM_PLUS;
				ptm_pkg::PTM_PAT_DROOP:
					next_st.tx_symbol = (st.pat_count < ptm_pkg::DROOP_HALF) ?
					                    ptm_pkg::SYM_PLUS : ptm_pkg::SYM_MINUS;
				default:
					next_st.tx_symbol = pcs_tx_symbol;
			endcase
		end

		// Strap high forbids the high level
		next_st.lvl_high = st.strap_done && !st.strap_latched &&
		                   (st.an_allow ? an_level_high : st.lvl_req);

		// Read data captured in the setup phase
		if (psel && !penable)
		begin
			next_st.rdata = 32'h0000_0000;
			case (paddr)
				ptm_pkg::ADDR_CTRL:
				begin
					next_st.rdata[ptm_pkg::CTRL_PD_BIT]          = st.pd_req;
					next_st.rdata[ptm_pkg::CTRL_AN_BIT]          = st.an_allow;
					next_st.rdata[ptm_pkg::CTRL_FRC_BIT]         = st.an_forced;
					next_st.rdata[ptm_pkg::CTRL_ZERO_BIT]        = st.zero_en;
					next_st.rdata[ptm_pkg::CTRL_PAT_LSB +: 2]    = st.pattern;
					next_st.rdata[ptm_pkg::CTRL_LVL_BIT]         = st.lvl_req;
				end
				ptm_pkg::ADDR_STATUS:
				begin
					next_st.rdata[ptm_pkg::ST_PD_BIT]            = st.pd_reached;
					next_st.rdata[ptm_pkg::ST_STRAP_BIT]         = st.strap_latched;
					next_st.rdata[ptm_pkg::ST_LVL_BIT]           = st.lvl_high;
					next_st.rdata[ptm_pkg::ST_IND_A_BIT]         = ind_a_high;
					next_st.rdata[ptm_pkg::ST_IND_B_BIT]         = ind_b_high;
					next_st.rdata[ptm_pkg::ST_SENSE_BIT]         = ind_a_busy || ind_b_busy;
					next_st.rdata[ptm_pkg::ST_TX_BIT]            = st.tx_en;
				end
				ptm_pkg::ADDR_IND:
				begin
					next_st.rdata[ptm_pkg::IND_A_LSB +: 2]       = st.ind_a_mode;
					next_st.rdata[ptm_pkg::IND_B_LSB +: 2]       = st.ind_b_mode;
				end
				default:
				begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st          <= '0;
			st.an_allow <= ptm_pkg::AN_ALLOW_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Indicator drivers
	ptm_indicator #(
		.SENSE_CYCLES (SENSE_WAIT)
	) u_ind_a (
		.clk         (clk),
		.nrst        (nrst),
		.mode        (st.ind_a_mode),
		.sense_start (st.sense_kick),
		.activity    (link_activity_a),
		.pin_in      (indicator_out_a_in),
		.pin_out     (indicator_out_a_out),
		.pin_oe      (indicator_out_a_oe),
		.active_high (ind_a_high),
		.sense_busy  (ind_a_busy)
	);

	ptm_indicator #(
		.SENSE_CYCLES (SENSE_WAIT)
	) u_ind_b (
		.clk         (clk),
		.nrst        (nrst),
		.mode        (st.ind_b_mode),
		.sense_start (st.sense_kick),
		.activity    (link_activity_b),
		.pin_in      (indicator_out_b_in),
		.pin_out     (indicator_out_b_out),
		.pin_oe      (indicator_out_b_oe),
		.active_high (ind_b_high),
		.sense_busy  (ind_b_busy)
	);

	// Outputs from registers
	assign prdata                = st.rdata;
	assign tx_symbol             = st.tx_symbol;
	assign tx_path_enable        = st.tx_en;
	assign rx_path_enable        = st.rx_en;
	assign tx_level_high         = st.lvl_high;
	assign autoneg_allow         = st.an_allow;
	assign autoneg_forced_config = st.an_forced;

	property p_pd_reached;
		@(posedge clk) disable iff (!nrst)
		(st.pd_req && !st.pd_reached) |-> ##[1:PD_WAIT] (st.pd_reached || !st.pd_req);
	endproperty
	a_pd_reached: assert property (p_pd_reached) else $error("power-down not reached in time");

	property p_pd_early;
		@(posedge clk) disable iff (!nrst)
		$rose(st.pd_req) |-> !st.pd_reached ##1 !st.pd_reached;
	endproperty
	a_pd_early: assert property (p_pd_early) else $error("power-down reached too early");

	property p_strap_low_level;
		@(posedge clk) disable iff (!nrst)
		(st.strap_done && st.strap_latched) |=> !tx_level_high;
	endproperty
	a_strap_low_level: assert property (p_strap_low_level) else $error("high level with strap high");

	property p_level_permit;
		@(posedge clk) disable iff (!nrst)
		(st.strap_done && !st.strap_latched && !st.an_allow && st.lvl_req) |=> tx_level_high;
	endproperty
	a_level_permit: assert property (p_level_permit) else $error("high level refused with strap low");

	property p_alt_pattern;
		@(posedge clk) disable iff (!nrst)
		(run_alt ##1 run_alt) |=> (tx_symbol != $past(tx_symbol) && tx_symbol != ptm_pkg::SYM_ZERO);
	endproperty
	a_alt_pattern: assert property (p_alt_pattern) else $error("alternating pattern broken");

	property p_droop_plus;
		@(posedge clk) disable iff (!nrst)
		(run_droop && st.pat_count == 5'h09) |=> (tx_symbol == ptm_pkg::SYM_PLUS);
	endproperty
	a_droop_plus: assert property (p_droop_plus) else $error("droop plus run wrong");

	property p_droop_wrap;
		@(posedge clk) disable iff (!nrst)
		(run_droop && st.pat_count == 5'h13) |=> (tx_symbol == ptm_pkg::SYM_MINUS && st.pat_count == 5'h00);
	endproperty
	a_droop_wrap: assert property (p_droop_wrap) else $error("droop wrap wrong");

	property p_zero_mode;
		@(posedge clk) disable iff (!nrst)
		st.zero_en |=> (tx_symbol == ptm_pkg::SYM_ZERO && tx_path_enable && rx_path_enable);
	endproperty
	a_zero_mode: assert property (p_zero_mode) else $error("zero mode output wrong");

	property p_zero_exit;
		@(posedge clk) disable iff (!nrst)
		(bus_write && paddr == ptm_pkg::ADDR_CTRL && !pwdata[ptm_pkg::CTRL_PD_BIT]) |=> (!st.zero_en ##1 tx_path_enable);
	endproperty
	a_zero_exit: assert property (p_zero_exit) else $error("power-down clear did not resume");

	property p_normal_code;
		@(posedge clk) disable iff (!nrst)
		(run_tx && st.pattern == ptm_pkg::PTM_PAT_NORMAL) |=> (tx_symbol == $past(pcs_tx_symbol));
	endproperty
	a_normal_code: assert property (p_normal_code) else $error("normal code not passing data");

endmodule : ptm_test_entry

// ---- verification/ptm_led_model.sv ----
// Indicator pin circuits: pull-up on A, pull-down on B
`timescale 1ns/10ps
module ptm_led_model (
	input  wire logic a_out,
	input  wire logic a_oe,
	input  wire logic b_out,
	input  wire logic b_oe,
	output logic      a_pin,
	output logic      b_pin
);
	// Released pin goes to its pull level
	assign a_pin = a_oe ? a_out : 1'b1;
	assign b_pin = b_oe ? b_out : 1'b0;
endmodule : ptm_led_model

// ---- verification/testbench.sv ----
// Register level bench for the test mode entry block
`timescale 1ns/10ps
module testbench;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;  // Bus and reset
	logic        strap, an_hi, act_a, act_b, a_in, a_out, a_oe, b_in, b_out, b_oe;
	logic        tx_en, rx_en, lvl, an, frc;                              // Observed outputs
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  pcs, sym;
	int          error_cnt, compares;

	// Short counts keep the run brief
	ptm_test_entry #(.PD_SETTLE(2), .SENSE_WAIT(3)) ptm_test_entry_i (
		.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .high_level_tx_strap(strap), .pcs_tx_symbol(pcs),
		.an_level_high(an_hi), .link_activity_a(act_a), .link_activity_b(act_b),
		.indicator_out_a_in(a_in), .indicator_out_a_out(a_out), .indicator_out_a_oe(a_oe),
		.indicator_out_b_in(b_in), .indicator_out_b_out(b_out), .indicator_out_b_oe(b_oe),
		.tx_symbol(sym), .tx_path_enable(tx_en), .rx_path_enable(rx_en),
		.tx_level_high(lvl), .autoneg_allow(an), .autoneg_forced_config(frc));

	ptm_led_model ptm_led_model_i (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
		.a_pin(a_in), .b_pin(b_in));

	// Free running 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Counted comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
			begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
	endtask : chk

	// One APB transfer, held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the watchdog ends a wait for pready
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e); xfer(1'b0, a, 0); chk(rd, e); endtask : rc
	task automatic settle; repeat (3) @(posedge clk); #1; endtask : settle

	// Symbol stream whose sign flips every h symbols
	task automatic pat(input int h);
		logic [1:0] s [0:20];
		int t, z;
		t = 0;
		z = 0;
		settle;
		for (int i = 0; i <= 20; i++) begin @(negedge clk); s[i] = sym; end
		for (int i = 1; i <= 20; i++) if (s[i] !== s[i-1]) t++;
		for (int i = 0; i + h <= 20; i++) if (s[i] === s[i+h] || s[i] === ptm_pkg::SYM_ZERO) z++;
		chk(t, 20 / h);
		chk(z, 0);
	endtask : pat

	// Verdict and end of run
	task automatic print_verdict;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// Watchdog against a hung handshake
	initial
	begin
		#400_000;
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict;
	end

	// Main sequence
	initial
	begin
		{nrst, psel, penable, pwrite, paddr, pwdata, rd} = '0;
		{strap, an_hi, act_a, act_b} = 4'hF;
		pcs = ptm_pkg::SYM_PLUS;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		rc(ptm_pkg::ADDR_CTRL, 32'h0000_0002);
		rc(ptm_pkg::ADDR_IND, 32'h0000_0000);
		rc(ptm_pkg::ADDR_STATUS, 32'h0000_0052);
		chk({a_out, a_oe, b_out, b_oe, lvl}, 5'h0E);
		wr(ptm_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		rc(ptm_pkg::ADDR_STATUS, 32'h0000_0052);
		rc(8'h10, 32'h0000_0000);
		chk(err, 1'b1);
		wr(ptm_pkg::ADDR_IND, 32'h0000_0002);
		settle;
		chk(a_out, 1'b1);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0003);
		settle;
		chk(tx_en, 1'b0);
		for (int i = 0; i < 20 && rd[0] !== 1'b1; i++) xfer(1'b0, ptm_pkg::ADDR_STATUS, 0);
		chk(rd[0], 1'b1);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0001);
		settle;
		chk(an, 1'b0);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0005);
		settle;
		chk(frc, 1'b1);
		for (int p = 1; p <= 3; p++)
			begin
			wr(ptm_pkg::ADDR_CTRL, 32'h0000_0005 | (p << 4));
			wr(ptm_pkg::ADDR_CTRL, 32'h0000_0004 | (p << 4));
			if (p < 3) pat(p == 1 ? 1 : 10);
			end
		settle;
		chk(sym, ptm_pkg::SYM_PLUS);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0044);
		settle;
		chk(lvl, 1'b0);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0005);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_000D);
		settle;
		chk({tx_en, rx_en, sym}, 4'hC);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0004);
		rc(ptm_pkg::ADDR_CTRL, 32'h0000_0004);
		rc(ptm_pkg::ADDR_STATUS, 32'h0000_0052);
		chk({tx_en, sym}, 3'h5);
		strap <= 1'b0;
		wr(ptm_pkg::ADDR_RESET, 32'h0000_0001);
		repeat (10) @(posedge clk);
		rc(ptm_pkg::ADDR_CTRL, 32'h0000_0002);
		rc(ptm_pkg::ADDR_IND, 32'h0000_0000);
		chk({lvl, a_out, a_oe}, 3'h5);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0000);
		settle;
		chk(lvl, 1'b0);
		wr(ptm_pkg::ADDR_CTRL, 32'h0000_0040);
		settle;
		chk(lvl, 1'b1);
		print_verdict;
	end
endmodule : testbench
